// [fps_defines.svh]
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH

// ==========================================
// register byte offsets
`define FPS_OFS_CMD 8'h00
`define FPS_OFS_PTR 8'h04
`define FPS_OFS_DMASK 8'h08
`define FPS_OFS_PMASK 8'h0C
`define FPS_OFS_MISC 8'h10
`define FPS_OFS_NMI_STATUS_REGISTER 8'h14
`define FPS_OFS_NMI_CONTROL_REGISTER 8'h18
`define FPS_OFS_RESULT 8'h1C
// wordline data buffer, eight words at 0x20..0x3C
`define FPS_BUF_PAGE 3'h1
`define FPS_BUF_SEL 7:5
`define FPS_BUF_IDX 4:2

// ==========================================
// command word fields
`define FPS_CMD_OP 1:0
`define FPS_CMD_PROG 2'h1
`define FPS_CMD_ERASE 2'h2
`define FPS_CMD_BLK 2

// ==========================================
// field positions
`define FPS_MISC_PROT0 0
`define FPS_MISC_PROT1 1
`define FPS_MISC_UNLOCK 2
`define FPS_RES_CARRY 0
`define FPS_RES_BUSY 1
`define FPS_RES_BANK 7:4
`define FPS_PMASK_LANE 8
`define FPS_BANK_HI 14
`define FPS_BANK_LO 13

// ==========================================
// wordline geometry and bank count
`define FPS_PTR_STEP 16'h0020
`define FPS_WL_MASK 16'h001F
`define FPS_WL_LAST 3'h7
`define FPS_NBANK 4

`endif

// [fps_pkg.sv]
package fps_pkg;

    typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_START, ST_WAIT, ST_RET} fps_st_t;

    // nmi status and mask layout: done is bit 0
    typedef struct packed {
        logic pll;
        logic core;
        logic io;
        logic done;
    } fps_nmi_t;

    typedef struct packed {
        logic pll;
        logic core;
        logic io;
    } fps_mon_t;

    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } fps_avm_req_t;

    typedef struct packed {
        logic start;
        logic erase;
        logic abort;
        logic wr;
        logic [2:0] widx;
        logic [31:0] wdata;
        logic [15:0] addr;
        logic [9:0] dsel;
        logic [2:0][2:0] psel;
    } fps_flash_req_t;

    typedef struct packed {
        fps_st_t st;
        logic blk;
        logic erase;
        logic nmi_seen;
        logic [15:0] write_pointer;
        logic [9:0] dmask;
        logic [2:0][2:0] pmask;
        logic [2:0] misc_control_register;
        fps_nmi_t nmi_status_register;
        fps_nmi_t nmi_control_register;
        logic result_carry_flag;
        logic rd_ack;
        logic [31:0] rdata;
        logic [7:0][31:0] wl_buf;
        logic [2:0] widx;
        fps_flash_req_t fl;
        fps_mon_t mon_s1;
        fps_mon_t mon_s2;
        fps_mon_t mon_prev;
    } fps_state_t;

endpackage

// [fps_bank_busy.sv]
`timescale 1ns/100ps

module fps_bank_busy #(
    parameter int NBANK = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // busy control from the sequencer
    input wire logic [NBANK-1:0] set_mask,
    input wire logic clr_all,
    // flash read port
    input wire logic rd_req,
    input wire logic [$clog2(NBANK)-1:0] rd_bank,
    output logic [NBANK-1:0] busy,
    output logic rd_grant
);
    logic [NBANK-1:0] busy_reg;
    logic [NBANK-1:0] busy_next;

    // a new operation can only start after clr_all, so set winning is safe
    for (genvar g = 0; g < NBANK; g++) begin : g_bank
        always_comb begin
            busy_next[g] = set_mask[g] || (busy_reg[g] && !clr_all); // [RULE19]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            busy_reg <= '0;
        end else if (clk_en) begin
            busy_reg <= busy_next;
        end
    end

    assign busy = busy_reg;
    assign rd_grant = rd_req && !busy_reg[rd_bank]; // [RULE19]

    // ==========================================
    // checks
    a_read_blocked: assert property (@(posedge clk) disable iff (reset) // [RULE19]
        busy_reg[rd_bank] |-> !rd_grant) else $error("read granted to busy bank");
endmodule

// [fps_sequencer.sv]
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "fps_defines.svh"
// ==========================================
// Functional notes
// RULE1: blocking program returns 0 on success, 1 on protection mode 1 or event
// RULE2: blocking program and erase clear the flash done flag before returning
// RULE3: write pointer advances by 0x20 only when the returned status is 0
// RULE4: requester supplies a wordline address with low five bits zero
// RULE5: one erase request takes one sector or any mix of sectors
// RULE6: data-flash mask: first byte sectors 0-7, second byte bits 0-1 sectors 8-9
// RULE7: each program bank 0..2 has its own mask byte, bits 0-2 select sectors
// RULE8: requester zeroes every mask byte of banks not to be erased
// RULE9: background erase returns at once, 0 started, 1 not; bank stays busy
// RULE10: background completion sets done flag; interrupt only if enabled
// RULE11: when completion is raised all banks are ready to read
// RULE12: protection mode 0 data-flash erase needs the unlock bit, else status 1
// RULE13: blocking erase holds the requester until done; no background work
// RULE14: blocking erase aborts when a supply or pll warning flag is set
// RULE15: blocking erase fails on missing unlock, protection mode 1 or event
// RULE16: requester disables interrupts and writes 00 to nmi status first
// RULE17: requester should not target erase-protected banks
// RULE18: each program request writes 32 bytes into one wordline
// RULE19: per-bank busy from acceptance to completion blocks reads

module fps_sequencer (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // avalon-mm slave
    input wire fps_pkg::fps_avm_req_t avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // flash macro
    output fps_pkg::fps_flash_req_t fl_req,
    input wire logic fl_done,
    // asynchronous monitor levels
    input wire logic io_supply_warn,
    input wire logic core_supply_warn,
    input wire logic pll_lock_loss,
    // flash read port
    input wire logic rd_req,
    input wire logic [1:0] rd_bank,
    output logic rd_grant,
    output logic [3:0] bank_busy,
    // interrupt
    output logic nmi_irq
);
    fps_pkg::fps_state_t s_reg;
    fps_pkg::fps_state_t s_next;
    logic cmd_wr;
    logic cmd_prog;
    logic cmd_valid;
    logic cmd_blk;
    logic dflash_locked;
    logic fail_cmd;
    logic crit;
    logic blk_res;
    logic [3:0] erase_banks;
    logic [3:0] prog_bank;
    logic [3:0] busy_set;
    logic busy_clr;
    logic [31:0] rd_word;
    fps_pkg::fps_mon_t mon_rise;

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================
    // request decode
    assign cmd_wr = avs_req.write && avs_req.address == `FPS_OFS_CMD && avs_req.byteenable[0];
    assign cmd_prog = avs_req.writedata[`FPS_CMD_OP] == `FPS_CMD_PROG;
    assign cmd_valid = cmd_wr && (cmd_prog || avs_req.writedata[`FPS_CMD_OP] == `FPS_CMD_ERASE);
    assign cmd_blk = avs_req.writedata[`FPS_CMD_BLK];
    assign erase_banks = {|s_reg.dmask, |s_reg.pmask[2], |s_reg.pmask[1], |s_reg.pmask[0]}; // [RULE5]
    assign prog_bank = 4'h1 << s_reg.write_pointer[`FPS_BANK_HI:`FPS_BANK_LO];
    assign dflash_locked = s_reg.misc_control_register[`FPS_MISC_PROT0]
        && !s_reg.misc_control_register[`FPS_MISC_UNLOCK] && |s_reg.dmask; // [RULE12]
    // a request while another is running is refused, not queued
    assign fail_cmd = s_reg.misc_control_register[`FPS_MISC_PROT1] // [RULE1] [RULE15]
        || (!cmd_prog && (!(|erase_banks) || dflash_locked))
        || s_reg.st != fps_pkg::ST_IDLE;
    assign crit = s_reg.nmi_status_register.io || s_reg.nmi_status_register.core
        || s_reg.nmi_status_register.pll;
    assign blk_res = s_reg.nmi_seen || crit;
    assign mon_rise = s_reg.mon_s2 & ~s_reg.mon_prev;

    // accepted blocking commands stall the bus until the operation ends
    assign avs_waitrequest = (avs_req.read && !s_reg.rd_ack)
        || (cmd_valid && cmd_blk && (s_reg.st == fps_pkg::ST_IDLE ? !fail_cmd // [RULE13]
            : (s_reg.blk && s_reg.st != fps_pkg::ST_RET)));
    assign avs_readdata = s_reg.rdata;
    assign fl_req = s_reg.fl;
    assign nmi_irq = |(s_reg.nmi_status_register & s_reg.nmi_control_register); // [RULE10]

    // ==========================================
    // next state
    always_comb begin
        s_next = s_reg;
        s_next.fl.start = 1'b0;
        s_next.fl.abort = 1'b0;
        s_next.fl.wr = 1'b0;
        s_next.rd_ack = 1'b0;
        busy_set = 4'h0;
        busy_clr = 1'b0;
        rd_word = 32'h0;
        s_next.mon_s1 = {pll_lock_loss, core_supply_warn, io_supply_warn};
        s_next.mon_s2 = s_reg.mon_s1;
        s_next.mon_prev = s_reg.mon_s2;

        case (avs_req.address)
            `FPS_OFS_PTR: begin
                rd_word = 32'(s_reg.write_pointer);
            end
            `FPS_OFS_DMASK: begin
                rd_word = 32'(s_reg.dmask);
            end
            `FPS_OFS_PMASK: begin
                for (int k = 0; k < 3; k++) begin
                    rd_word[k*`FPS_PMASK_LANE +: 3] = s_reg.pmask[k];
                end
            end
            `FPS_OFS_MISC: begin
                rd_word = 32'(s_reg.misc_control_register);
            end
            `FPS_OFS_NMI_STATUS_REGISTER: begin
                rd_word = 32'(s_reg.nmi_status_register);
            end
            `FPS_OFS_NMI_CONTROL_REGISTER: begin
                rd_word = 32'(s_reg.nmi_control_register);
            end
            `FPS_OFS_RESULT: begin
                rd_word[`FPS_RES_CARRY] = s_reg.result_carry_flag;
                rd_word[`FPS_RES_BUSY] = s_reg.st != fps_pkg::ST_IDLE;
                rd_word[`FPS_RES_BANK] = bank_busy;
            end
            default: begin
                if (avs_req.address[`FPS_BUF_SEL] == `FPS_BUF_PAGE) begin
                    rd_word = s_reg.wl_buf[avs_req.address[`FPS_BUF_IDX]];
                end
            end
        endcase
        if (avs_req.read && !s_reg.rd_ack) begin
            s_next.rd_ack = 1'b1;
            s_next.rdata = rd_word;
        end
        // status clears on the edge that completes its read
        if (avs_req.read && s_reg.rd_ack && avs_req.address == `FPS_OFS_NMI_STATUS_REGISTER) begin
            s_next.nmi_status_register = '0;
        end

        if (avs_req.write) begin
            case (avs_req.address)
                `FPS_OFS_PTR: begin
                    s_next.write_pointer = 16'(be_merge(32'(s_reg.write_pointer),
                        avs_req.writedata, avs_req.byteenable));
                end
                `FPS_OFS_DMASK: begin
                    s_next.dmask = 10'(be_merge(32'(s_reg.dmask), avs_req.writedata, // [RULE6]
                        avs_req.byteenable));
                end
                `FPS_OFS_PMASK: begin
                    for (int k = 0; k < 3; k++) begin
                        if (avs_req.byteenable[k]) begin
                            s_next.pmask[k] = avs_req.writedata[k*`FPS_PMASK_LANE +: 3]; // [RULE7]
                        end
                    end
                end
                `FPS_OFS_MISC: begin
                    s_next.misc_control_register = 3'(be_merge(32'(s_reg.misc_control_register),
                        avs_req.writedata, avs_req.byteenable));
                end
                `FPS_OFS_NMI_STATUS_REGISTER: begin
                    s_next.nmi_status_register = 4'(be_merge(32'(s_reg.nmi_status_register),
                        avs_req.writedata, avs_req.byteenable));
                end
                `FPS_OFS_NMI_CONTROL_REGISTER: begin
                    s_next.nmi_control_register = 4'(be_merge(32'(s_reg.nmi_control_register),
                        avs_req.writedata, avs_req.byteenable));
                end
                default: begin
                    if (avs_req.address[`FPS_BUF_SEL] == `FPS_BUF_PAGE) begin
                        s_next.wl_buf[avs_req.address[`FPS_BUF_IDX]] = be_merge(
                            s_reg.wl_buf[avs_req.address[`FPS_BUF_IDX]], avs_req.writedata,
                            avs_req.byteenable);
                    end
                end
            endcase
        end

        // background work in flight: flag the refusal so software does not read a stale 0
        if (cmd_valid && s_reg.st != fps_pkg::ST_IDLE && !s_reg.blk) begin
            s_next.result_carry_flag = 1'b1; // [RULE9]
        end

        case (s_reg.st)
            fps_pkg::ST_IDLE: begin
                if (cmd_valid && fail_cmd) begin
                    s_next.result_carry_flag = 1'b1; // [RULE9] [RULE12] [RULE15]
                end else if (cmd_valid) begin
                    s_next.blk = cmd_blk;
                    s_next.erase = !cmd_prog;
                    s_next.nmi_seen = 1'b0;
                    s_next.widx = 3'h0;
                    s_next.fl.addr = s_reg.write_pointer & ~`FPS_WL_MASK;
                    s_next.fl.dsel = s_reg.dmask; // [RULE5] [RULE6]
                    s_next.fl.psel = s_reg.pmask; // [RULE7]
                    busy_set = cmd_prog ? prog_bank : erase_banks; // [RULE19]
                    s_next.st = cmd_prog ? fps_pkg::ST_LOAD : fps_pkg::ST_START;
                    if (!cmd_blk) begin
                        s_next.result_carry_flag = 1'b0; // [RULE9]
                        if (cmd_prog) begin
                            s_next.write_pointer = s_reg.write_pointer + `FPS_PTR_STEP; // [RULE3]
                        end
                    end
                end
            end
            fps_pkg::ST_LOAD: begin
                s_next.fl.wr = 1'b1; // [RULE18]
                s_next.fl.widx = s_reg.widx;
                s_next.fl.wdata = s_reg.wl_buf[s_reg.widx];
                s_next.widx = s_reg.widx + 3'h1;
                if (s_reg.widx == `FPS_WL_LAST) begin
                    s_next.st = fps_pkg::ST_START;
                end
            end
            fps_pkg::ST_START: begin
                s_next.fl.start = 1'b1;
                s_next.fl.erase = s_reg.erase;
                s_next.st = fps_pkg::ST_WAIT;
            end
            fps_pkg::ST_WAIT: begin
                if (s_reg.blk) begin
                    if (crit) begin
                        s_next.nmi_seen = 1'b1;
                    end
                    // only erase is aborted; a program is left to finish and then failed
                    if (s_reg.erase && crit) begin
                        s_next.fl.abort = 1'b1; // [RULE14]
                    end
                    if ((s_reg.erase && crit) || fl_done) begin
                        s_next.result_carry_flag = blk_res; // [RULE1] [RULE15]
                        s_next.nmi_status_register.done = 1'b0; // [RULE2]
                        busy_clr = 1'b1;
                        s_next.st = fps_pkg::ST_RET;
                        if (!s_reg.erase && !blk_res) begin
                            s_next.write_pointer = s_reg.write_pointer + `FPS_PTR_STEP; // [RULE3]
                        end
                    end
                end else if (fl_done) begin
                    s_next.nmi_status_register.done = 1'b1; // [RULE10]
                    busy_clr = 1'b1; // [RULE11]
                    s_next.st = fps_pkg::ST_IDLE;
                end
            end
            fps_pkg::ST_RET: begin
                s_next.nmi_status_register.done = 1'b0; // [RULE2]
                s_next.st = fps_pkg::ST_IDLE;
            end
            default: begin
                s_next.st = fps_pkg::ST_IDLE;
            end
        endcase

        // monitor events set after all clears so that a set wins
        s_next.nmi_status_register.io = s_next.nmi_status_register.io || mon_rise.io;
        s_next.nmi_status_register.core = s_next.nmi_status_register.core || mon_rise.core;
        s_next.nmi_status_register.pll = s_next.nmi_status_register.pll || mon_rise.pll;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg <= '0;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    // ==========================================
    // bank busy tracking
    fps_bank_busy #(
        .NBANK(`FPS_NBANK)
    ) u_busy (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .set_mask(busy_set),
        .clr_all(busy_clr),
        .rd_req(rd_req),
        .rd_bank(rd_bank),
        .busy(bank_busy),
        .rd_grant(rd_grant)
    );

    // ==========================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    logic acc_idle;
    assign acc_idle = clk_en && s_reg.st == fps_pkg::ST_IDLE && cmd_valid;

    a_prot_prog_fail: assert property ( // [RULE1]
        acc_idle && cmd_prog && s_reg.misc_control_register[`FPS_MISC_PROT1]
        |=> s_reg.result_carry_flag && s_reg.st == fps_pkg::ST_IDLE)
        else $error("program under protection mode 1 not failed");
    a_blk_done_clear: assert property ( // [RULE2]
        clk_en && s_reg.st == fps_pkg::ST_WAIT && s_reg.blk && fl_done
        |=> s_reg.st == fps_pkg::ST_RET && !s_reg.nmi_status_register.done)
        else $error("done flag left set by blocking request");
    a_ptr_advance: assert property ( // [RULE3]
        acc_idle && cmd_prog && !cmd_blk && !fail_cmd
        |=> s_reg.write_pointer == 16'($past(s_reg.write_pointer) + `FPS_PTR_STEP))
        else $error("write pointer not advanced");
    a_ptr_hold_fail: assert property ( // [RULE3]
        acc_idle && fail_cmd |=> $stable(s_reg.write_pointer))
        else $error("write pointer moved on failure");
    a_erase_select: assert property ( // [RULE5]
        acc_idle && !cmd_prog && !fail_cmd
        |=> s_reg.fl.dsel == $past(s_reg.dmask) && s_reg.fl.psel == $past(s_reg.pmask)
            && bank_busy == $past(erase_banks))
        else $error("erase selection not passed on");
    a_bg_erase_ret: assert property ( // [RULE9]
        acc_idle && !cmd_prog && !cmd_blk && !fail_cmd
        |-> !avs_waitrequest ##1 !s_reg.result_carry_flag && bank_busy != 4'h0)
        else $error("background erase did not return at once");
    a_bg_done_ready: assert property ( // [RULE11]
        clk_en && s_reg.st == fps_pkg::ST_WAIT && !s_reg.blk && fl_done
        |=> s_reg.nmi_status_register.done && bank_busy == 4'h0)
        else $error("completion raised while a bank is busy");
    a_dflash_lock: assert property ( // [RULE12]
        acc_idle && !cmd_prog && dflash_locked |=> s_reg.result_carry_flag && bank_busy == 4'h0)
        else $error("locked data-flash erase was started");
    a_blk_hold: assert property ( // [RULE13]
        s_reg.blk && (s_reg.st == fps_pkg::ST_WAIT || s_reg.st == fps_pkg::ST_START) |-> avs_waitrequest)
        else $error("requester released during blocking operation");
    a_crit_abort: assert property ( // [RULE14]
        clk_en && s_reg.st == fps_pkg::ST_WAIT && s_reg.blk && s_reg.erase && crit
        |=> s_reg.fl.abort && s_reg.result_carry_flag ##1 s_reg.st != fps_pkg::ST_WAIT)
        else $error("blocking erase not aborted on warning");
    a_load_last: assert property ( // [RULE18]
        clk_en && s_reg.st == fps_pkg::ST_LOAD && s_reg.widx == `FPS_WL_LAST
        |=> s_reg.st == fps_pkg::ST_START && s_reg.fl.wr && s_reg.fl.widx == `FPS_WL_LAST)
        else $error("wordline load length wrong");

    c_bg_erase_done: cover property (s_reg.st == fps_pkg::ST_WAIT && !s_reg.blk && s_reg.erase && fl_done);
    c_blk_abort: cover property (s_reg.st == fps_pkg::ST_WAIT && s_reg.blk && s_reg.erase && crit);
    c_blk_prog_ok: cover property (s_reg.st == fps_pkg::ST_RET && !s_reg.erase && !s_reg.result_carry_flag);
    c_refused: cover property (cmd_valid && s_reg.st == fps_pkg::ST_WAIT && !s_reg.blk);
endmodule

// [fps_flash_model.sv]
`timescale 1ns/100ps
// ==========================================
// flash macro stand-in: done pulse dly cycles after start, abort cancels it
module fps_flash_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // sequencer side
    input wire fps_pkg::fps_flash_req_t fl_req,
    input wire logic [7:0] dly,
    output logic fl_done,
    output logic [7:0] nwr
);
    logic [7:0] cnt;
    always_ff @(posedge clk) begin
        fl_done <= 1'b0;
        if (reset) begin
            cnt <= 8'h00;
            nwr <= 8'h00;
        end else begin
            if (fl_req.wr) nwr <= nwr + 8'h01;
            if (fl_req.abort) cnt <= 8'h00;
            else if (fl_req.start) cnt <= dly;
            else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
                fl_done <= (cnt == 8'h01);
            end
        end
    end
endmodule

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    fps_pkg::fps_avm_req_t avs_req = '0;
    fps_pkg::fps_flash_req_t fl_req;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, fl_done, rd_grant, nmi_irq;
    logic rd_req = 1'b0, io_w = 1'b0, core_w = 1'b0, pll_w = 1'b0;
    logic [1:0] rd_bank = 2'h3;
    logic [3:0] bank_busy;
    logic [7:0] dly = 8'h28, nwr, w;
    integer seed = 32'hab93;
    int miscompares = 0, checked = 0, cyc = 0, ptr, n;

    fps_sequencer u_dut (.clk(clk), .reset(reset), .clk_en(1'b1), .avs_req(avs_req),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fl_req(fl_req), .fl_done(fl_done),
        .io_supply_warn(io_w), .core_supply_warn(core_w), .pll_lock_loss(pll_w), .rd_req(rd_req),
        .rd_bank(rd_bank), .rd_grant(rd_grant), .bank_busy(bank_busy), .nmi_irq(nmi_irq));
    fps_flash_model u_flash (.clk(clk), .reset(reset), .fl_req(fl_req), .dly(dly), .fl_done(fl_done), .nwr(nwr));

    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    // one bus cycle; held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_req.address <= a;
        avs_req.write <= wr;
        avs_req.read <= !wr;
        avs_req.writedata <= d;
        avs_req.byteenable <= 4'hF;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_req.read <= 1'b0;
        avs_req.write <= 1'b0;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        bus(1'b0, 8'h14, 32'h0);
        chk32(q, 32'h0);
        $display("test reset done");
        bus(1'b1, 8'h10, 32'h5);
        for (int en = 0; en < 2; en++) begin
            bus(1'b1, 8'h18, en);
            bus(1'b1, 8'h08, 32'h201);
            bus(1'b1, 8'h0C, 32'h40201);
            bus(1'b1, 8'h00, 32'h2);
            rd_req <= 1'b1;
            @(negedge clk);
            chk32({28'h0, bank_busy}, 32'hF);
            chk1(rd_grant, 1'b0);
            bus(1'b0, 8'h1C, 32'h0);
            chk1(q[0], 1'b0);
            bus(1'b1, 8'h00, 32'h6);
            bus(1'b0, 8'h1C, 32'h0);
            chk1(q[0], 1'b1);
            n = 0;
            while (bank_busy !== 4'h0 && n < 500) begin
                @(posedge clk);
                n++;
            end
            @(negedge clk);
            chk1(nmi_irq, en[0]);
            chk1(rd_grant, 1'b1);
            bus(1'b0, 8'h14, 32'h0);
            chk32(q, 32'h1);
            @(negedge clk);
            chk1(nmi_irq, 1'b0);
        end
        rd_req <= 1'b0;
        $display("test background erase done");
        bus(1'b1, 8'h10, 32'h1);
        bus(1'b1, 8'h08, 32'h3FF);
        for (int c = 2; c < 7; c += 4) begin
            bus(1'b1, 8'h00, c);
            bus(1'b0, 8'h1C, 32'h0);
            chk32(q, 32'h1);
        end
        $display("test erase refusal done");
        dly <= 8'h05;
        ptr = ($random(seed) & 32'h1FE0) | 32'h2000;
        bus(1'b1, 8'h10, 32'h0);
        bus(1'b1, 8'h04, ptr);
        for (int i = 0; i < 8; i++) bus(1'b1, 8'h20 + 8'(4 * i), $random(seed));
        bus(1'b1, 8'h18, 32'h0);
        bus(1'b1, 8'h14, 32'h0);
        w = nwr;
        bus(1'b1, 8'h00, 32'h5);
        chk32(32'(nwr - w), 32'h8);
        bus(1'b0, 8'h1C, 32'h0);
        chk1(q[0], 1'b0);
        chk32(32'(fl_req.addr), ptr);
        ptr = ptr + 32'h20;
        bus(1'b0, 8'h04, 32'h0);
        chk32(q, ptr);
        bus(1'b0, 8'h14, 32'h0);
        chk32(q, 32'h0);
        bus(1'b1, 8'h10, 32'h2);
        bus(1'b1, 8'h00, 32'h5);
        bus(1'b0, 8'h1C, 32'h0);
        chk1(q[0], 1'b1);
        bus(1'b0, 8'h04, 32'h0);
        chk32(q, ptr);
        bus(1'b1, 8'h10, 32'h0);
        bus(1'b1, 8'h00, 32'h1);
        ptr = ptr + 32'h20;
        bus(1'b0, 8'h04, 32'h0);
        chk32(q, ptr);
        repeat (40) @(posedge clk);
        chk32({28'h0, bank_busy}, 32'h0);
        $display("test blocking program done");
        bus(1'b1, 8'h10, 32'h5);
        bus(1'b1, 8'h08, ($random(seed) & 32'h3FF) | 32'h1);
        bus(1'b1, 8'h0C, 32'h0);
        bus(1'b1, 8'h14, 32'h0);
        bus(1'b1, 8'h00, 32'h6);
        bus(1'b0, 8'h1C, 32'h0);
        chk1(q[0], 1'b0);
        bus(1'b0, 8'h14, 32'h0);
        chk32(q, 32'h0);
        dly <= 8'h64;
        fork
            bus(1'b1, 8'h00, 32'h6);
            begin
                repeat (20) @(posedge clk);
                pll_w <= 1'b1;
            end
        join
        pll_w <= 1'b0;
        bus(1'b0, 8'h1C, 32'h0);
        chk1(q[0], 1'b1);
        bus(1'b0, 8'h14, 32'h0);
        chk32(q, 32'h8);
        $display("test blocking erase done");
        summarize();
    end
endmodule
